/* hw/pio_pkg.sv */
package pio_pkg;

  // ------------------------------------------------------------
  // register offsets on the wishbone side (byte addresses)
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_STATUS = 5'h00; // status byte, bsy and drq
  localparam logic [4:0] OFS_CONFIG = 5'h04; // own logical device number
  localparam logic [4:0] OFS_DEVCTL = 5'h08; // device control, read only
  localparam logic [4:0] OFS_FEATURES = 5'h0C; // features, read only
  localparam logic [4:0] OFS_SECCNT = 5'h10; // sector count, read only
  localparam logic [4:0] OFS_DEVICE = 5'h14; // device register, read only
  localparam logic [4:0] OFS_DATA = 5'h18; // write: word for host, read: host word
  localparam logic [4:0] OFS_EVENTS = 5'h1C; // sticky events, write one to clear

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BSY_BIT = 7; // status busy
  localparam int DRQ_BIT = 3; // status data request
  localparam int DEV_BIT = 4; // device register select bit
  localparam int NIEN_BIT = 1; // device control interrupt disable
  localparam int SRST_BIT = 2; // device control software reset
  localparam int EV_DATA_W = 0; // host wrote a data word
  localparam int EV_DATA_R = 1; // host read a data word
  localparam int EV_HOST_ERR = 2; // discarded write while drq set

  // ------------------------------------------------------------
  // address lines on the host port
  // ------------------------------------------------------------
  localparam logic [2:0] DA_DATA = 3'h0;
  localparam logic [2:0] DA_FEATURES = 3'h1;
  localparam logic [2:0] DA_SECCNT = 3'h2;
  localparam logic [2:0] DA_DEVICE = 3'h6;
  localparam logic [2:0] DA_STATUS = 3'h7;
  localparam logic [2:0] DA_DEVCTL = 3'h6;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic RST_OWN_DEV = 1'b0;

  // host pins, all active low strobes and selects
  typedef struct packed {
    logic cs0_n;
    logic cs1_n;
    logic [2:0] da;
    logic dior_n;
    logic diow_n;
    logic [15:0] dd;
  } pins_t;

  localparam pins_t PINS_IDLE = '{cs0_n: 1'b1, cs1_n: 1'b1, da: 3'h0,
                                  dior_n: 1'b1, diow_n: 1'b1, dd: 16'h0000};

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_READ = 3'h2,
    ST_WRITE = 3'h4
  } fsm_t;

  typedef enum logic [3:0] {
    ACT_NONE = 4'h0,
    ACT_DEVCTL_W = 4'h1,
    ACT_STATUS_R = 4'h2,
    ACT_DATA_R = 4'h3,
    ACT_DATA_W = 4'h4,
    ACT_FEAT_W = 4'h5,
    ACT_SECCNT_W = 4'h6,
    ACT_DEVICE_W = 4'h7,
    ACT_REJECT = 4'h8,
    ACT_ZERO_R = 4'h9
  } act_t;

  // whole state of the decoder
  typedef struct packed {
    pins_t sync1;
    pins_t sync2;
    fsm_t fsm;
    act_t act;
    logic [15:0] wdata;
    logic [7:0] status;
    logic own_dev;
    logic [7:0] devctl;
    logic [7:0] features;
    logic [7:0] seccnt;
    logic [7:0] device;
    logic [15:0] data_out;
    logic [15:0] data_in;
    logic [2:0] events;
    logic [15:0] dd_out;
    logic dd_oe;
    logic ack;
    logic [31:0] rdata;
  } dev_state_t;

  localparam dev_state_t STATE_RST = '{
    sync1: PINS_IDLE, sync2: PINS_IDLE, fsm: ST_IDLE, act: ACT_NONE,
    wdata: RST_WORD, status: RST_STATUS, own_dev: RST_OWN_DEV,
    devctl: RST_BYTE, features: RST_BYTE, seccnt: RST_BYTE, device: RST_BYTE,
    data_out: RST_WORD, data_in: RST_WORD, events: 3'h0, dd_out: RST_WORD,
    dd_oe: 1'b0, ack: 1'b0, rdata: 32'h0000_0000};

endpackage

/* hw/pio_decode.sv */
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps

// Summary of operation
// - selected only when dev bit matches own
// - control write loads device control, always
// - control read returns status, interrupt untouched
// - no chip select or unused control ignored
// - data address, bsy0 drq1: one word moves
// - command block access while busy is undefined
// - command write with drq set is discarded when selected; unselected takes it
// - status read when not busy returns status
module pio_decode (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire pio_pkg::pins_t host_i,
  output logic [15:0] dd_out,
  output logic dd_oe,
  output logic nien,
  output logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pio_pkg::dev_state_t s_q; // registered state
  pio_pkg::dev_state_t s_d; // next state
  pio_pkg::pins_t pin; // synchronised pins
  logic rd_on; // read strobe alone asserted
  logic wr_on; // write strobe alone asserted
  logic selected; // dev bit equals own number
  logic [2:0] ev_set; // events raised this cycle
  logic [2:0] ev_clr; // events cleared by software
  logic wb_wr; // wishbone write taking effect

  // pick the action for one strobe, taken once at its leading edge
  function automatic pio_pkg::act_t decode(input pio_pkg::pins_t p, input logic is_rd,
                                           input logic sel, input logic bsy,
                                           input logic drq);
    pio_pkg::act_t a;
    a = pio_pkg::ACT_NONE;
    if (p.cs0_n && !p.cs1_n) begin
      // control block: only one address is used
      if (p.da == pio_pkg::DA_DEVCTL) begin
        if (!is_rd) begin
          a = pio_pkg::ACT_DEVCTL_W;
        end else if (sel) begin
          a = pio_pkg::ACT_STATUS_R;
        end
      end
    end else if (!p.cs0_n && p.cs1_n) begin
      if (bsy) begin
        // outcome undefined; ignoring is the safest choice
        a = pio_pkg::ACT_NONE;
      end else if (!sel) begin
        // unselected: reads are left to the other device
        if (!is_rd) begin
          unique case (p.da)
            pio_pkg::DA_FEATURES: a = pio_pkg::ACT_FEAT_W;
            pio_pkg::DA_SECCNT: a = pio_pkg::ACT_SECCNT_W;
            pio_pkg::DA_DEVICE: a = pio_pkg::ACT_DEVICE_W;
            default: a = pio_pkg::ACT_NONE;
          endcase
        end
      end else if (drq) begin
        if (p.da == pio_pkg::DA_DATA) begin
          a = is_rd ? pio_pkg::ACT_DATA_R : pio_pkg::ACT_DATA_W;
        end else if (!is_rd) begin
          a = pio_pkg::ACT_REJECT;
        end else begin
          a = (p.da == pio_pkg::DA_STATUS) ? pio_pkg::ACT_STATUS_R : pio_pkg::ACT_ZERO_R;
        end
      end else if (is_rd) begin
        // not busy: status read returns live status
        a = (p.da == pio_pkg::DA_STATUS) ? pio_pkg::ACT_STATUS_R : pio_pkg::ACT_ZERO_R;
      end else begin
        unique case (p.da)
          pio_pkg::DA_FEATURES: a = pio_pkg::ACT_FEAT_W;
          pio_pkg::DA_SECCNT: a = pio_pkg::ACT_SECCNT_W;
          pio_pkg::DA_DEVICE: a = pio_pkg::ACT_DEVICE_W;
          default: a = pio_pkg::ACT_NONE; // other registers not handled here
        endcase
      end
    end
    return a;
  endfunction

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // two-stage synchroniser; only sync2 is looked at
    s_d.sync1 = host_i;
    s_d.sync2 = s_q.sync1;
    pin = s_q.sync2;
    rd_on = !pin.dior_n && pin.diow_n;
    wr_on = !pin.diow_n && pin.dior_n;
    selected = (s_q.device[pio_pkg::DEV_BIT] == s_q.own_dev);
    ev_set = 3'h0;
    ev_clr = 3'h0;
    wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack;

    // host strobe sequencer
    unique case (s_q.fsm)
      pio_pkg::ST_IDLE: begin
        // both strobes low at once is treated as no strobe
        if (rd_on || wr_on) begin
          s_d.act = decode(pin, rd_on, selected, s_q.status[pio_pkg::BSY_BIT],
                           s_q.status[pio_pkg::DRQ_BIT]);
          s_d.fsm = rd_on ? pio_pkg::ST_READ : pio_pkg::ST_WRITE;
          s_d.wdata = pin.dd;
        end
      end
      pio_pkg::ST_READ: begin
        if (pin.dior_n) begin
          // trailing edge ends the cycle and the drive
          s_d.fsm = pio_pkg::ST_IDLE;
          s_d.dd_oe = 1'b0;
          if (s_q.act == pio_pkg::ACT_DATA_R) begin
            ev_set[pio_pkg::EV_DATA_R] = 1'b1;
          end
        end else begin
          s_d.dd_oe = (s_q.act != pio_pkg::ACT_NONE);
          unique case (s_q.act)
            pio_pkg::ACT_STATUS_R: s_d.dd_out = {8'h00, s_q.status};
            pio_pkg::ACT_DATA_R: s_d.dd_out = s_q.data_out;
            default: s_d.dd_out = 16'h0000;
          endcase
        end
      end
      pio_pkg::ST_WRITE: begin
        if (pin.diow_n) begin
          // data is taken as last seen before the trailing edge
          s_d.fsm = pio_pkg::ST_IDLE;
          unique case (s_q.act)
            pio_pkg::ACT_DEVCTL_W: s_d.devctl = s_q.wdata[7:0];
            pio_pkg::ACT_FEAT_W: s_d.features = s_q.wdata[7:0];
            pio_pkg::ACT_SECCNT_W: s_d.seccnt = s_q.wdata[7:0];
            pio_pkg::ACT_DEVICE_W: s_d.device = s_q.wdata[7:0];
            pio_pkg::ACT_DATA_W: begin
              s_d.data_in = s_q.wdata;
              ev_set[pio_pkg::EV_DATA_W] = 1'b1;
            end
            pio_pkg::ACT_REJECT: ev_set[pio_pkg::EV_HOST_ERR] = 1'b1;
            default: s_d.act = pio_pkg::ACT_NONE;
          endcase
        end else begin
          s_d.wdata = pin.dd;
        end
      end
    endcase

    // wishbone slave: ack one cycle after the request, dropped next
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    unique case (wb_adr_i)
      pio_pkg::OFS_STATUS: s_d.rdata = {24'h000000, s_q.status};
      pio_pkg::OFS_CONFIG: s_d.rdata = {31'h0, s_q.own_dev};
      pio_pkg::OFS_DEVCTL: s_d.rdata = {24'h000000, s_q.devctl};
      pio_pkg::OFS_FEATURES: s_d.rdata = {24'h000000, s_q.features};
      pio_pkg::OFS_SECCNT: s_d.rdata = {24'h000000, s_q.seccnt};
      pio_pkg::OFS_DEVICE: s_d.rdata = {24'h000000, s_q.device};
      pio_pkg::OFS_DATA: s_d.rdata = {16'h0000, s_q.data_in};
      pio_pkg::OFS_EVENTS: s_d.rdata = {29'h0, s_q.events};
      default: s_d.rdata = 32'h0000_0000; // unmapped reads zero, still acked
    endcase
    // writes land at the edge where the master sees ack
    if (wb_wr && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        pio_pkg::OFS_STATUS: s_d.status = wb_dat_i[7:0];
        pio_pkg::OFS_CONFIG: s_d.own_dev = wb_dat_i[0];
        pio_pkg::OFS_DATA: s_d.data_out[7:0] = wb_dat_i[7:0];
        pio_pkg::OFS_EVENTS: ev_clr = wb_dat_i[2:0];
        default: ev_clr = 3'h0;
      endcase
    end
    if (wb_wr && wb_sel_i[1] && wb_adr_i == pio_pkg::OFS_DATA) begin
      s_d.data_out[15:8] = wb_dat_i[15:8];
    end
    // a new event beats a clear in the same cycle
    s_d.events = (s_q.events & ~ev_clr) | ev_set;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= pio_pkg::STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign dd_out = s_q.dd_out;
  assign dd_oe = s_q.dd_oe;
  assign nien = s_q.devctl[pio_pkg::NIEN_BIT];
  assign srst = s_q.devctl[pio_pkg::SRST_BIT];
  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  logic wr_done; // write strobe trailing edge seen
  assign wr_done = (s_q.fsm == pio_pkg::ST_WRITE) && s_q.sync2.diow_n;

  sequence seq_wr_end(pio_pkg::act_t a);
    wr_done && (s_q.act == a);
  endsequence

  sequence seq_rd_drive(pio_pkg::act_t a);
    (s_q.fsm == pio_pkg::ST_READ) && !s_q.sync2.dior_n && (s_q.act == a);
  endsequence

  a_devctl_load: assert property (seq_wr_end(pio_pkg::ACT_DEVCTL_W) |=>
    (s_q.devctl == $past(s_q.wdata[7:0])) &&
    (srst == $past(s_q.wdata[pio_pkg::SRST_BIT])))
    else $error("device control not loaded");
  a_status_drive: assert property (seq_rd_drive(pio_pkg::ACT_STATUS_R) |=>
    dd_oe && (dd_out == {8'h00, $past(s_q.status)}))
    else $error("status not driven on read");
  // act keeps the last action while idle, so only a new strobe is judged here
  a_ignore_nosel: assert property ((s_q.fsm == pio_pkg::ST_IDLE) &&
    s_q.sync2.cs0_n && s_q.sync2.cs1_n && (rd_on || wr_on) |=>
    (s_q.act == pio_pkg::ACT_NONE) ##1 !dd_oe)
    else $error("cycle without chip select acted");
  a_data_word: assert property (seq_rd_drive(pio_pkg::ACT_DATA_R) |=>
    dd_oe && (dd_out == $past(s_q.data_out)))
    else $error("data word not driven");
  a_busy_ignore: assert property ((s_q.fsm == pio_pkg::ST_IDLE) &&
    s_q.status[pio_pkg::BSY_BIT] && !s_q.sync2.cs0_n && s_q.sync2.cs1_n &&
    (rd_on || wr_on) |=> (s_q.act == pio_pkg::ACT_NONE))
    else $error("busy access not ignored");
  a_reject_write: assert property (seq_wr_end(pio_pkg::ACT_REJECT) |=>
    s_q.events[pio_pkg::EV_HOST_ERR] && $stable(s_q.features) && $stable(s_q.seccnt))
    else $error("write with drq set not discarded");
  a_features_store: assert property (seq_wr_end(pio_pkg::ACT_FEAT_W) |=>
    (s_q.features == $past(s_q.wdata[7:0])))
    else $error("features not stored");
  a_seccnt_store: assert property (seq_wr_end(pio_pkg::ACT_SECCNT_W) |=>
    (s_q.seccnt == $past(s_q.wdata[7:0])))
    else $error("sector count not stored");
  a_unsel_quiet: assert property (!selected && (s_q.fsm == pio_pkg::ST_IDLE) &&
    rd_on |=> (s_q.act == pio_pkg::ACT_NONE))
    else $error("unselected device answered a read");
  a_status_idle: assert property (seq_rd_drive(pio_pkg::ACT_STATUS_R) &&
    !s_q.status[pio_pkg::BSY_BIT] |=> dd_out[7:0] == $past(s_q.status))
    else $error("status read while idle wrong");
  a_one_action: assert property (wr_done |=> (s_q.fsm == pio_pkg::ST_IDLE) &&
    $stable(s_q.act) ##1 (s_q.fsm == pio_pkg::ST_IDLE) || $changed(s_q.act))
    else $error("more than one action per strobe");

endmodule

/* testbench/host_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// host adapter model for the parallel register port
// ------------------------------------------------------------
module host_model (
  input wire logic sys_clk,
  input wire logic [15:0] dd_out,
  input wire logic dd_oe,
  output pio_pkg::pins_t pins
);
  pio_pkg::pins_t drv_q; // selects, address and strobes
  logic [15:0] hdd_q; // host write data
  logic hdd_en_q; // host drives the data wire
  logic [15:0] last_q; // last wire level

  // resolved data wire; a released wire toggles so stale data never matches
  always_comb begin
    pins = drv_q;
    pins.dd = hdd_en_q ? hdd_q : (dd_oe ? dd_out : ~last_q);
  end

  // remember the wire for the released case
  always @(posedge sys_clk) begin
    last_q <= pins.dd;
  end

  // idle pins from time zero
  initial begin
    drv_q = pio_pkg::PINS_IDLE;
    hdd_q = 16'h0000;
    hdd_en_q = 1'b0;
    last_q = 16'h0000;
  end

  // one strobe cycle: address set up first, 6 cycles asserted, 6 negated
  task automatic xfer(input logic cs0_n, input logic cs1_n, input logic [2:0] da,
                      input logic wr, input logic [15:0] wd,
                      output logic [15:0] rd, output logic oe);
    @(posedge sys_clk);
    drv_q.cs0_n <= cs0_n;
    drv_q.cs1_n <= cs1_n;
    drv_q.da <= da;
    hdd_q <= wd;
    hdd_en_q <= wr;
    @(posedge sys_clk);
    drv_q.diow_n <= !wr;
    drv_q.dior_n <= wr;
    repeat (6) @(posedge sys_clk);
    rd = pins.dd;
    oe = dd_oe;
    drv_q.diow_n <= 1'b1;
    drv_q.dior_n <= 1'b1;
    // data held past the rise so the trailing edge sees it
    repeat (4) @(posedge sys_clk);
    hdd_en_q <= 1'b0;
    repeat (2) @(posedge sys_clk);
    drv_q <= pio_pkg::PINS_IDLE;
  endtask
endmodule

/* testbench/selected_device_pio_register_decode_tb.sv */
`timescale 1ns/1ps

module selected_device_pio_register_decode_tb;
  localparam logic [1:0] CMD = 2'h2; // cs0 asserted: bit0 is cs0_n, bit1 is cs1_n
  localparam logic [1:0] CTL = 2'h1; // cs1 asserted
  localparam logic [1:0] NOCS = 2'h3; // no select
  logic sys_clk;
  logic arst_n;
  pio_pkg::pins_t host_pins;
  logic [15:0] dd_out;
  logic dd_oe;
  logic nien;
  logic srst;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [4:0] wb_adr;
  logic [3:0] wb_sel; // byte enables, raised with the request
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  int n_errors;
  int n_compared;
  logic [15:0] rd;
  logic oe;
  logic [31:0] v;

  pio_decode uut (.sys_clk(sys_clk), .arst_n(arst_n), .host_i(host_pins),
    .dd_out(dd_out), .dd_oe(dd_oe), .nien(nien), .srst(srst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack));

  host_model host (.sys_clk(sys_clk), .dd_out(dd_out), .dd_oe(dd_oe), .pins(host_pins));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // classic single cycle; the wait is bounded so a silent slave ends the run
  task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'h3;
    wb_dat_w <= wd;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    v = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      end_sim();
    end
  endtask

  task automatic rdchk(input logic [4:0] adr, input logic [31:0] exp, input string what);
    wb(1'b0, adr, 32'h0000_0000);
    chk(v, exp, what);
  endtask

  task automatic hwr(input logic [1:0] cs, input logic [2:0] da, input logic [15:0] wd);
    host.xfer(cs[0], cs[1], da, 1'b1, wd, rd, oe);
  endtask

  task automatic hrd(input logic [1:0] cs, input logic [2:0] da);
    host.xfer(cs[0], cs[1], da, 1'b0, 16'h0000, rd, oe);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_ignore();
    rdchk(pio_pkg::OFS_FEATURES, 32'h0000_0000, "features reset");
    hwr(NOCS, pio_pkg::DA_FEATURES, 16'h005A);
    rdchk(pio_pkg::OFS_FEATURES, 32'h0000_0000, "no select write");
    for (int i = 0; i < 8; i++) begin
      if (i != 6) begin
        hwr(CTL, 3'(i), 16'h00FF);
      end
    end
    rdchk(pio_pkg::OFS_DEVCTL, 32'h0000_0000, "unused control write");
    hrd(NOCS, pio_pkg::DA_STATUS);
    chk(32'(oe), 32'h0000_0000, "no select read drive");
    $display("test ignore done");
  endtask

  task automatic t_ctl();
    wb(1'b1, pio_pkg::OFS_STATUS, 32'h0000_0080);
    hwr(CTL, pio_pkg::DA_DEVCTL, 16'h0006);
    chk(32'({nien, srst}), 32'h0000_0003, "control bits while busy");
    rdchk(pio_pkg::OFS_DEVCTL, 32'h0000_0006, "control register");
    hrd(CTL, pio_pkg::DA_DEVCTL);
    chk(32'({oe, rd[7:0]}), 32'h0000_0180, "control read status");
    hwr(CTL, pio_pkg::DA_DEVCTL, 16'h0000);
    chk(32'({nien, srst}), 32'h0000_0000, "control bits cleared");
    $display("test control done");
  endtask

  task automatic t_regs();
    wb(1'b1, pio_pkg::OFS_STATUS, 32'h0000_0041);
    hwr(CMD, pio_pkg::DA_FEATURES, 16'h00A5);
    hwr(CMD, pio_pkg::DA_SECCNT, 16'h003C);
    rdchk(pio_pkg::OFS_FEATURES, 32'h0000_00A5, "features");
    rdchk(pio_pkg::OFS_SECCNT, 32'h0000_003C, "sector count");
    hrd(CMD, pio_pkg::DA_STATUS);
    chk(32'({oe, rd[7:0]}), 32'h0000_0141, "status read");
    hrd(CMD, pio_pkg::DA_SECCNT);
    chk(32'({oe, rd}), 32'h0001_0000, "other register read");
    $display("test registers done");
  endtask

  task automatic t_data();
    wb(1'b1, pio_pkg::OFS_STATUS, 32'h0000_0008);
    wb(1'b1, pio_pkg::OFS_EVENTS, 32'h0000_0007);
    wb(1'b1, pio_pkg::OFS_DATA, 32'h0000_BEEF);
    hrd(CMD, pio_pkg::DA_DATA);
    chk(32'({oe, rd}), 32'h0001_BEEF, "data word to host");
    hwr(CMD, pio_pkg::DA_DATA, 16'h1234);
    hwr(CMD, pio_pkg::DA_DATA, 16'h5678);
    rdchk(pio_pkg::OFS_DATA, 32'h0000_5678, "data word from host");
    rdchk(pio_pkg::OFS_EVENTS, 32'h0000_0003, "data events");
    $display("test data done");
  endtask

  task automatic t_err();
    wb(1'b1, pio_pkg::OFS_EVENTS, 32'h0000_0007);
    hwr(CMD, pio_pkg::DA_FEATURES, 16'h0077);
    rdchk(pio_pkg::OFS_FEATURES, 32'h0000_00A5, "discarded write");
    rdchk(pio_pkg::OFS_EVENTS, 32'h0000_0004, "host error event");
    $display("test host error done");
  endtask

  task automatic t_busy();
    wb(1'b1, pio_pkg::OFS_STATUS, 32'h0000_0080);
    hwr(CMD, pio_pkg::DA_SECCNT, 16'h0099);
    rdchk(pio_pkg::OFS_SECCNT, 32'h0000_003C, "busy write");
    hrd(CMD, pio_pkg::DA_STATUS);
    chk(32'(oe), 32'h0000_0000, "busy read drive");
    $display("test busy done");
  endtask

  task automatic t_sel();
    wb(1'b1, pio_pkg::OFS_STATUS, 32'h0000_0000);
    hwr(CMD, pio_pkg::DA_DEVICE, 16'h0010);
    rdchk(pio_pkg::OFS_DEVICE, 32'h0000_0010, "device register");
    hrd(CMD, pio_pkg::DA_STATUS);
    chk(32'(oe), 32'h0000_0000, "unselected read");
    wb(1'b1, pio_pkg::OFS_CONFIG, 32'h0000_0001);
    hrd(CMD, pio_pkg::DA_STATUS);
    chk(32'({oe, rd[7:0]}), 32'h0000_0100, "selected read");
    $display("test select done");
  endtask

  // ------------------------------------------------------------
  // clock, reset and sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    arst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 5'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0000_0000;
    n_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_ignore();
    t_ctl();
    t_regs();
    t_data();
    t_err();
    t_busy();
    t_sel();
    end_sim();
  end
endmodule
